// File: scn_pkg.sv
// Shared constants and types of the scanner pixel path and its data port.
// How it works
// - Turbo runs front end Nx, averages N samples.
// - Preview speeds pixel clock, drops N-1 resets.
// - Timing setting range shrinks with turbo factor.
// - Horizontal divider combines with turbo or preview.
// - Divider code ten divides six, two two.
// - Horizontal division precedes offset and gain.
// - Offset is 14 bits, shifted left two.
// - Gain code over 16384, range zero to four.
// - Zero gain code forces zero corrected pixel.
// - Three gamma tables with 12-bit index.
// - Pause bit is read-only, others writable.
// - Two-bit selector picks offset, gain, gamma.
// - Word mode steps address every two bytes.
// - Byte mode steps address every byte.
// - Address is 14 bits, direction bit above.
// - Color bits pick gamma table for writes, for reads in one-channel only.
// - Address wraps from highest legal value; above it, steps on and wraps from 3fff.
package scn_pkg;
   localparam int          PIX_W      = 14;
   localparam int          COEF_AW    = 14;
   localparam int          COEF_W     = 16;
   localparam int          GAM_AW     = 12;
   localparam int          GAM_W      = 8;
   localparam int          GAM_TABLES = 3;
   localparam int          OUT_W      = 2 + PIX_W + GAM_W;
   localparam int          OFS_SHIFT  = 2;
   localparam int          GAIN_FRAC  = 14;
   localparam int          FIFO_DEPTH = 16;
   localparam int          RW_BIT     = 14;
   localparam int          CTL_PAUSE  = 0;
   localparam int          CTL_BYTE   = 1;
   localparam int          CTL_COL_LO = 2;
   localparam int          CTL_TGT_LO = 4;
   localparam logic [7:0]  CTL_RST    = 8'h00;
   localparam logic [13:0] COEF_MAX   = 14'h3fff;
   localparam logic [13:0] GAM_MAX    = 14'h0fff;
   localparam logic [4:0]  PER_3CH    = 5'h18;
   localparam logic [4:0]  PER_1CH    = 5'h08;
   localparam logic [3:0]  HDIV_MAX   = 4'hc;
   localparam logic [16:0] RATE_MIN   = 17'h00006;
   typedef enum logic [1:0] {SCN_TGT_OFS, SCN_TGT_GAIN, SCN_TGT_GAMMA, SCN_TGT_NONE} scn_tgt_t;
endpackage

// File: scn_mem_if.sv
// Interface joining the pixel path to one of its coefficient or gamma stores.
`timescale 1ns/100ps
`default_nettype none
interface scn_mem_if #(
   parameter int AW = 14,
   parameter int DW = 16
);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic          re;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport owner (output we, waddr, wdata, re, raddr, input rdata);
   modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

// File: scn_mem.sv
// Simple dual-port store with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module scn_mem #(
   parameter int AW = 14,
   parameter int DW = 16
) (
   // Clock and reset.
   input  wire logic i_mclk,
   input  wire logic i_arst_n,
   // Store port.
   scn_mem_if.store  io
);
   logic [DW-1:0] ram [2**AW];
   logic [DW-1:0] rdata_q;

   if (AW < 1 || DW < 1) begin : g_chk
      $error("scn_mem needs nonzero widths.");
   end

   always_ff @(posedge i_mclk) begin
      if (io.we) begin
         ram[io.waddr] <= io.wdata;
      end
   end

   // Read data holds while the path is stalled.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_q <= '0;
      end else if (io.re) begin
         rdata_q <= ram[io.raddr];
      end
   end

   assign io.rdata = rdata_q;
endmodule // scn_mem
`default_nettype wire

// File: scn_pix.sv
// Scanner pixel path: sensor timing, averaging, correction, gamma, data port, output FIFO.
`timescale 1ns/100ps
`default_nettype none
module scn_fifo #(
   parameter int W     = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic         i_mclk,
   input  wire logic         i_arst_n,
   // Fill side.
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   // Drain side.
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         full;
   logic         empty;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("scn_fifo depth must be a power of two of at least two.");
   end

   assign empty       = (wr_q == rd_q);
   assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge i_mclk) begin
      if (i_in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (i_in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (i_out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // scn_fifo

module scn_pix #(
   parameter int FIFO_DEPTH = scn_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic        i_mclk,
   input  wire logic        i_arst_n,
   // Configuration and status.
   input  wire logic        i_three_chan,
   input  wire logic [2:0]  i_turbo,
   input  wire logic [2:0]  i_preview,
   input  wire logic [4:0]  i_mclk_div_code,
   input  wire logic [3:0]  i_horizontal_res_divider,
   input  wire logic [7:0]  i_integration_stretch,
   input  wire logic [4:0]  i_rst_pos,
   input  wire logic        i_pause,
   output logic             o_rate_err,
   output logic             o_timing_err,
   // Sensor timing.
   output logic             o_sens_pclk,
   output logic             o_sens_reset,
   // Converted samples in.
   input  wire logic        i_line_start,
   input  wire logic        i_pix_valid,
   output logic             o_pix_ready,
   input  wire logic [13:0] i_pix_data,
   input  wire logic [1:0]  i_pix_color,
   // Data port.
   input  wire logic        i_ctl_we,
   input  wire logic [7:0]  i_ctl_wdata,
   output logic [7:0]       o_ctl_rdata,
   input  wire logic        i_addr_we,
   input  wire logic [15:0] i_addr_wdata,
   output logic [15:0]      o_addr_rdata,
   input  wire logic        i_data_we,
   input  wire logic [7:0]  i_data_wdata,
   // Processed pixels out.
   output logic             o_out_valid,
   input  wire logic        i_out_ready,
   output logic [23:0]      o_out_data
);
   localparam int PW = scn_pkg::PIX_W;
   localparam int GW = scn_pkg::GAM_W;

   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
      $error("FIFO_DEPTH must be a power of two of at least two.");
   end

   // Pixel period in divided clocks for the channel mode and speed factor.
   function automatic logic [4:0] period_of(input logic three, input logic [2:0] f);
      logic [4:0] base;
      logic [4:0] p;
      base = three ? scn_pkg::PER_3CH : scn_pkg::PER_1CH;
      case (f)
         3'h2: p = base >> 1;
         3'h3: p = base / 5'h03;
         3'h4: p = base >> 2;
         3'h6: p = base / 5'h06;
         default: p = base;
      endcase
      return p;
   endfunction

   // =======================================================
   // Sensor timing
   logic [4:0]  mdiv;
   logic [4:0]  div_q;
   logic [4:0]  period;
   logic [4:0]  phase_q;
   logic [4:0]  rst_at;
   logic [2:0]  pv_n;
   logic [2:0]  pv_q;
   logic        tick;
   logic        pix_last;
   logic        rst_bad;
   logic [3:0]  hn;
   logic [16:0] rate_prod;

   assign mdiv     = 5'(i_mclk_div_code >> 1) + 5'h01;
   assign tick     = (div_q >= mdiv - 5'h01);
   assign period   = period_of(i_three_chan, (i_turbo > 3'h1) ? i_turbo : i_preview);
   assign rst_bad  = (i_rst_pos >= period);
   assign rst_at   = rst_bad ? period - 5'h01 : i_rst_pos;
   assign pv_n     = (i_preview > 3'h1 && i_turbo <= 3'h1) ? i_preview : 3'h1;
   assign pix_last = tick && (phase_q >= period - 5'h01);
   assign hn       = (i_horizontal_res_divider == 4'h0) ? 4'h1 :
                     (i_horizontal_res_divider > scn_pkg::HDIV_MAX) ? scn_pkg::HDIV_MAX :
                     i_horizontal_res_divider;
   assign rate_prod = 17'(mdiv * hn * ((i_integration_stretch == 8'h00) ? 8'h01 :
                     i_integration_stretch));

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_q   <= 5'h00;
         phase_q <= 5'h00;
      end else begin
         div_q <= tick ? 5'h00 : div_q + 5'h01;
         if (tick) begin
            phase_q <= pix_last ? 5'h00 : phase_q + 5'h01;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pv_q <= 3'h0;
      end else if (pix_last) begin
         pv_q <= (pv_q >= pv_n - 3'h1) ? 3'h0 : pv_q + 3'h1;
      end
   end

   // Only the first pixel of each preview group gets its reset pulse.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sens_pclk  <= 1'b0;
         o_sens_reset <= 1'b0;
         o_timing_err <= 1'b0;
         o_rate_err   <= 1'b0;
      end else begin
         o_sens_pclk  <= tick && (phase_q == 5'h00);
         o_sens_reset <= tick && (phase_q == rst_at) && (pv_q == 3'h0);
         o_timing_err <= rst_bad;
         o_rate_err   <= (rate_prod < scn_pkg::RATE_MIN);
      end
   end

   // =======================================================
   // Data port
   logic [7:0]        ctl_q;
   logic [13:0]       addr_q;
   logic              rw_q;
   logic              hi_q;
   logic [7:0]        msb_q;
   logic              byte_mode;
   logic [1:0]        col_sel;
   scn_pkg::scn_tgt_t tgt;
   logic [13:0]       maxa;
   logic              step;

   assign byte_mode    = ctl_q[scn_pkg::CTL_BYTE];
   assign col_sel      = ctl_q[scn_pkg::CTL_COL_LO +: 2];
   assign tgt          = scn_pkg::scn_tgt_t'(ctl_q[scn_pkg::CTL_TGT_LO +: 2]);
   assign maxa         = (tgt == scn_pkg::SCN_TGT_GAMMA) ? scn_pkg::GAM_MAX : scn_pkg::COEF_MAX;
   assign step         = i_data_we && !i_addr_we && (byte_mode || hi_q);
   assign o_ctl_rdata  = ctl_q | (8'(i_pause) << scn_pkg::CTL_PAUSE);
   assign o_addr_rdata = {1'b0, rw_q, addr_q};

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctl_q <= scn_pkg::CTL_RST;
      end else if (i_ctl_we) begin
         ctl_q <= i_ctl_wdata & ~(8'h01 << scn_pkg::CTL_PAUSE);
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         addr_q <= 14'h0000;
         rw_q   <= 1'b0;
         hi_q   <= 1'b0;
         msb_q  <= 8'h00;
      end else if (i_addr_we) begin
         addr_q <= i_addr_wdata[13:0];
         rw_q   <= i_addr_wdata[scn_pkg::RW_BIT];
         hi_q   <= 1'b0;
      end else if (i_data_we) begin
         hi_q  <= byte_mode ? 1'b0 : !hi_q;
         msb_q <= i_data_wdata;
         if (step) begin
            addr_q <= (addr_q == maxa) ? 14'h0000 : addr_q + 14'h0001;
         end
      end
   end

   // =======================================================
   // Averaging and horizontal division
   logic              adv;
   logic              fire;
   logic [2:0]        tn;
   logic [2:0]        tcnt_q;
   logic [16:0]       acc_q;
   logic [16:0]       sum;
   logic              avg_v;
   logic [PW-1:0]     avg;
   logic [3:0]        hcnt_q;
   logic              keep;
   logic [13:0]       idx_q;

   assign fire  = i_pix_valid && adv;
   assign tn    = (i_turbo > 3'h1) ? i_turbo : 3'h1;
   assign sum   = acc_q + 17'(i_pix_data);
   assign avg_v = fire && (tcnt_q >= tn - 3'h1);
   assign keep  = avg_v && (hcnt_q == 4'h0);

   always_comb begin
      case (tn)
         3'h2: avg = PW'(sum >> 1);
         3'h3: avg = PW'(sum / 17'h00003);
         3'h4: avg = PW'(sum >> 2);
         3'h6: avg = PW'(sum / 17'h00006);
         default: avg = PW'(sum);
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tcnt_q <= 3'h0;
         acc_q  <= 17'h00000;
      end else if (i_line_start) begin
         tcnt_q <= 3'h0;
         acc_q  <= 17'h00000;
      end else if (fire) begin
         tcnt_q <= avg_v ? 3'h0 : tcnt_q + 3'h1;
         acc_q  <= avg_v ? 17'h00000 : sum;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hcnt_q <= 4'h0;
         idx_q  <= 14'h0000;
      end else if (i_line_start) begin
         hcnt_q <= 4'h0;
         idx_q  <= 14'h0000;
      end else begin
         if (avg_v) begin
            hcnt_q <= (hcnt_q >= hn - 4'h1) ? 4'h0 : hcnt_q + 4'h1;
         end
         if (keep) begin
            idx_q <= idx_q + 14'h0001;
         end
      end
   end

   // =======================================================
   // Offset, gain and gamma pipeline
   scn_mem_if #(.AW(scn_pkg::COEF_AW), .DW(scn_pkg::COEF_W)) ofs ();
   scn_mem_if #(.AW(scn_pkg::COEF_AW), .DW(scn_pkg::COEF_W)) gain ();
   logic              s1_v_q;
   logic [PW-1:0]     s1_pix_q;
   logic [1:0]        s1_col_q;
   logic              s2_v_q;
   logic [PW-1:0]     s2_pix_q;
   logic [1:0]        s2_col_q;
   logic [PW-1:0]     ofs14;
   logic [PW-1:0]     diff;
   logic [29:0]       prod;
   logic [15:0]       scaled;
   logic [PW-1:0]     corr;
   logic [GW-1:0]     gam_rd [scn_pkg::GAM_TABLES];
   logic [GW-1:0]     gam_sel;

   assign ofs.we    = i_data_we && !i_addr_we && !byte_mode && hi_q &&
                      (tgt == scn_pkg::SCN_TGT_OFS);
   assign gain.we   = i_data_we && !i_addr_we && !byte_mode && hi_q &&
                      (tgt == scn_pkg::SCN_TGT_GAIN);
   assign ofs.waddr  = addr_q;
   assign gain.waddr = addr_q;
   assign ofs.wdata  = {msb_q, i_data_wdata};
   assign gain.wdata = {msb_q, i_data_wdata};
   assign ofs.re     = adv;
   assign gain.re    = adv;
   assign ofs.raddr  = idx_q;
   assign gain.raddr = idx_q;

   scn_mem #(.AW(scn_pkg::COEF_AW), .DW(scn_pkg::COEF_W)) u_ofs (
      .i_mclk   (i_mclk),
      .i_arst_n (i_arst_n),
      .io       (ofs)
   );
   scn_mem #(.AW(scn_pkg::COEF_AW), .DW(scn_pkg::COEF_W)) u_gain (
      .i_mclk   (i_mclk),
      .i_arst_n (i_arst_n),
      .io       (gain)
   );

   assign ofs14  = ofs.rdata[scn_pkg::COEF_W-1:scn_pkg::OFS_SHIFT];
   assign diff   = (s1_pix_q > ofs14) ? s1_pix_q - ofs14 : '0;
   assign prod   = diff * gain.rdata;
   assign scaled = prod[scn_pkg::GAIN_FRAC +: 16];
   assign corr   = (scaled > 16'(scn_pkg::COEF_MAX)) ? scn_pkg::COEF_MAX : scaled[PW-1:0];

   for (genvar g = 0; g < scn_pkg::GAM_TABLES; g++) begin : g_gam
      scn_mem_if #(.AW(scn_pkg::GAM_AW), .DW(GW)) bus ();
      assign bus.we    = i_data_we && !i_addr_we && byte_mode && (addr_q <= scn_pkg::GAM_MAX) &&
                         (tgt == scn_pkg::SCN_TGT_GAMMA) && (col_sel == 2'(g));
      assign bus.waddr = addr_q[scn_pkg::GAM_AW-1:0];
      assign bus.wdata = i_data_wdata;
      assign bus.re    = adv;
      assign bus.raddr = corr[PW-1 -: scn_pkg::GAM_AW];
      assign gam_rd[g] = bus.rdata;
      scn_mem #(.AW(scn_pkg::GAM_AW), .DW(GW)) u_gam (
         .i_mclk   (i_mclk),
         .i_arst_n (i_arst_n),
         .io       (bus)
      );
   end

   assign gam_sel = (s2_col_q == 2'h3) ? '0 : gam_rd[s2_col_q];

   // Every stage moves only when the FIFO can take a word.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_v_q   <= 1'b0;
         s1_pix_q <= '0;
         s1_col_q <= 2'h0;
         s2_v_q   <= 1'b0;
         s2_pix_q <= '0;
         s2_col_q <= 2'h0;
      end else if (adv) begin
         s1_v_q   <= keep;
         s1_pix_q <= avg;
         s1_col_q <= i_three_chan ? i_pix_color : col_sel;
         s2_v_q   <= s1_v_q;
         s2_pix_q <= corr;
         s2_col_q <= s1_col_q;
      end
   end

   scn_fifo #(.W(scn_pkg::OUT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_mclk      (i_mclk),
      .i_arst_n    (i_arst_n),
      .i_in_valid  (s2_v_q),
      .o_in_ready  (adv),
      .i_in_data   ({s2_col_q, s2_pix_q, gam_sel}),
      .o_out_valid (o_out_valid),
      .i_out_ready (i_out_ready),
      .o_out_data  (o_out_data)
   );

   assign o_pix_ready = adv;

   // =======================================================
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);

   sequence gap_six_s;
      !tick [*5] ##1 tick;
   endsequence
   sequence first_byte_s;
      (i_data_we && !i_addr_we && !i_ctl_we && !byte_mode && !hi_q) ##1 (i_data_we && !i_addr_we);
   endsequence

   mclk_div_six_a: assert property (
      (tick && i_mclk_div_code == 5'h0a && $stable(i_mclk_div_code)) |=> gap_six_s)
      else $error("Divider code ten does not divide by six.");
   timing_clamp_a: assert property (
      (i_rst_pos >= period) |=> o_timing_err)
      else $error("Out of range timing setting not flagged.");
   zero_gain_a: assert property (
      (s1_v_q && adv && gain.rdata == 16'h0000) |=> (s2_v_q && s2_pix_q == '0))
      else $error("Zero gain code did not give zero.");
   unity_offset_a: assert property (
      (s1_v_q && adv && gain.rdata == 16'h4000 && s1_pix_q >= ofs14) |=>
      (s2_pix_q == $past(s1_pix_q) - $past(ofs14)))
      else $error("Offset subtraction at unity gain is wrong.");
   pause_ro_a: assert property (
      i_ctl_we |=> !ctl_q[scn_pkg::CTL_PAUSE])
      else $error("Pause bit was stored by a write.");
   word_step_a: assert property (
      (step && !byte_mode && addr_q != maxa) |=> addr_q == $past(addr_q) + 14'h0001)
      else $error("Word mode address did not advance.");
   byte_step_a: assert property (
      (i_data_we && !i_addr_we && !i_ctl_we && byte_mode && addr_q != maxa) |=>
      addr_q == $past(addr_q) + 14'h0001)
      else $error("Byte mode address did not advance.");
   addr_wrap_a: assert property (
      (step && !i_ctl_we && addr_q == maxa) |=> addr_q == 14'h0000)
      else $error("Address did not wrap from its top.");
   msb_first_a: assert property (
      first_byte_s |-> ofs.wdata[15:8] == $past(i_data_wdata))
      else $error("First byte not taken as high byte.");
   hdiv_index_a: assert property (
      (keep && !i_line_start) |=> idx_q == $past(idx_q) + 14'h0001)
      else $error("Pixel index did not follow kept pixels.");
endmodule // scn_pix
`default_nettype wire

// File: scn_host.sv
// Host-side model that loads coefficients and gamma data through the data port.
`timescale 1ns/100ps
`default_nettype none
module scn_host (
   // Clock.
   input  wire logic  i_mclk,
   // Data port.
   output logic        o_ctl_we,
   output logic [7:0]  o_ctl_wdata,
   output logic        o_addr_we,
   output logic [15:0] o_addr_wdata,
   output logic        o_data_we,
   output logic [7:0]  o_data_wdata
);
   // ==========================================================
   // Port writes.
   initial begin
      {o_ctl_we, o_addr_we, o_data_we} = 3'h0;
      {o_ctl_wdata, o_addr_wdata, o_data_wdata} = 32'h0;
   end

   // One strobe cycle per write; the bench calls this only while no scan runs.
   task automatic put(input logic [1:0] k, input logic [15:0] v);
      @(posedge i_mclk);
      #1;
      {o_ctl_we, o_addr_we, o_data_we} = {k == 2'h0, k == 2'h1, k == 2'h2};
      {o_ctl_wdata, o_addr_wdata, o_data_wdata} = {v[7:0], v, v[7:0]};
      @(posedge i_mclk);
      #1;
      {o_ctl_we, o_addr_we, o_data_we} = 3'h0;
      // Released data lines show the inverse so stale values are never reused.
      {o_ctl_wdata, o_addr_wdata, o_data_wdata} = ~{v[7:0], v, v[7:0]};
   endtask

   // Both bytes of a word go out on consecutive edges with the strobe held high.
   task automatic word(input logic [15:0] v);
      @(posedge i_mclk);
      #1;
      o_data_we    = 1'b1;
      o_data_wdata = v[15:8];
      @(posedge i_mclk);
      #1;
      o_data_wdata = v[7:0];
      @(posedge i_mclk);
      #1;
      o_data_we    = 1'b0;
      o_data_wdata = ~v[7:0];
   endtask
endmodule // scn_host
`default_nettype wire

// File: scn_pix_tb.sv
// Self-checking bench of the scanner pixel path and its data port.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module scn_pix_tb;
   logic        mclk, arst_n, three, pause, lstart, pvalid, pready, oready, ovalid;
   logic        rate_err, tim_err, pclk, sreset, cwe, awe, dwe;
   logic [2:0]  turbo, prev;
   logic [4:0]  dcode, rpos;
   logic [3:0]  hdiv;
   logic [7:0]  stretch, cwd, crd, dwd;
   logic [13:0] pdata;
   logic [1:0]  pcol;
   logic [15:0] awd, ard;
   logic [23:0] odata, w;
   logic [23:0] q[$];
   logic [23:0] ex[24];
   int          err_count, checks_done, cyc, hold, seed, n, t, h, k, s, c;
   int          px[24], cl[24], of[24], gn[24];
   bit          full;
   int th[7] = '{1, 1, 1, 1, 0, 0, 1};
   int tu[7] = '{1, 2, 6, 4, 1, 2, 3};
   int cd[7] = '{0, 0, 0, 2, 0, 0, 10};
   int pr[7] = '{24, 12, 4, 6, 8, 4, 8};
   int rc[6] = '{0, 0, 2, 2, 0, 0};
   int rh[6] = '{1, 6, 3, 2, 2, 1};
   int rs[6] = '{0, 0, 0, 0, 3, 5};
   int re[6] = '{1, 0, 0, 1, 0, 1};
   int tt[4] = '{1, 2, 1, 3};
   int hh[4] = '{1, 1, 3, 2};

   scn_pix #(.FIFO_DEPTH(16)) i_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_three_chan(three),
      .i_turbo(turbo), .i_preview(prev), .i_mclk_div_code(dcode),
      .i_horizontal_res_divider(hdiv), .i_integration_stretch(stretch), .i_rst_pos(rpos),
      .i_pause(pause), .o_rate_err(rate_err), .o_timing_err(tim_err), .o_sens_pclk(pclk),
      .o_sens_reset(sreset), .i_line_start(lstart), .i_pix_valid(pvalid),
      .o_pix_ready(pready), .i_pix_data(pdata), .i_pix_color(pcol), .i_ctl_we(cwe),
      .i_ctl_wdata(cwd), .o_ctl_rdata(crd), .i_addr_we(awe), .i_addr_wdata(awd),
      .o_addr_rdata(ard), .i_data_we(dwe), .i_data_wdata(dwd), .o_out_valid(ovalid),
      .i_out_ready(oready), .o_out_data(odata));
   scn_host i_host (.i_mclk(mclk), .o_ctl_we(cwe), .o_ctl_wdata(cwd), .o_addr_we(awe),
      .o_addr_wdata(awd), .o_data_we(dwe), .o_data_wdata(dwd));

   // ==========================================================
   // Helpers.
   function automatic logic [7:0] gv(logic [11:0] i, logic [1:0] c);
      return i[7:0] ^ i[11:4] ^ {c, 6'h15};
   endfunction

   function automatic logic [23:0] want(int p, int o, int g, int c);
      logic [31:0] v;
      v = (p > o) ? 32'(((p - o) * g) >>> 14) : 32'h0;
      if (v > 16383) v = 16383;
      return {c[1:0], v[13:0], gv(v[13:2], c[1:0])};
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic gap(input bit rsel, output int m);
      m = 0;
      do @(posedge mclk); while ((rsel ? sreset : pclk) !== 1'b1 && ++m < 500);
      m = 0;
      do begin
         @(posedge mclk);
         m++;
      end while ((rsel ? sreset : pclk) !== 1'b1 && m < 500);
   endtask

   task automatic send(int p, int cc);
      int b;
      {pvalid, pdata, pcol} = {1'b1, 14'(p), 2'(cc)};
      b = 0;
      do begin
         @(posedge mclk);
         if (pready !== 1'b1) full = 1'b1;
         b++;
      end while (pready !== 1'b1 && b < 300);
      #1;
   endtask

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // The drain side stalls at random, and fully while hold is ahead.
   initial begin
      oready = 1'b0;
      forever begin
         @(posedge mclk);
         #1;
         oready = (cyc < hold) ? 1'b0 : (($random(seed) & 1) != 0);
      end
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end

   always @(posedge mclk) if (ovalid === 1'b1 && oready === 1'b1) begin
      w = (q.size() != 0) ? q.pop_front() : 24'hx;
      `CHK("pixel", w, odata)
   end

   // ==========================================================
   // Main sequence.
   initial begin
      seed = 84284;
      {arst_n, three, pause, lstart, pvalid, pdata, pcol} = 21'h08000;
      {turbo, prev, dcode, rpos, hdiv, stretch} = 28'h0;
      repeat (10) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      `CHK("ctl reset", 8'h00, crd)
      `CHK("addr reset", 16'h0000, ard)
      pause = 1'b1;
      i_host.put(2'h0, 16'h0025);
      `CHK("ctl", 8'h25, crd)
      pause = 1'b0;
      #1;
      `CHK("ctl", 8'h24, crd)
      i_host.put(2'h1, 16'hffff);
      `CHK("addr", 16'h7fff, ard)
      i_host.put(2'h0, 16'h0000);
      i_host.put(2'h1, 16'h3fff);
      i_host.put(2'h2, 16'h0012);
      `CHK("addr", 16'h3fff, ard)
      i_host.put(2'h2, 16'h0034);
      `CHK("addr", 16'h0000, ard)
      i_host.put(2'h0, 16'h0022);
      i_host.put(2'h1, 16'h0fff);
      i_host.put(2'h2, 16'h0056);
      `CHK("addr", 16'h0000, ard)
      i_host.put(2'h1, 16'h1000);
      i_host.put(2'h2, 16'h0078);
      `CHK("addr", 16'h1001, ard)
      for (int r = 0; r < 7; r++) begin
         {three, turbo, dcode, rpos} = {th[r][0], 3'(tu[r]), 5'(cd[r]), 5'h00};
         gap(1'b0, n);
         gap(1'b0, n);
         `CHK("pclk gap", pr[r] * (cd[r] / 2 + 1), n)
         #1;
         rpos = 5'(pr[r]);
         repeat (3) @(posedge mclk);
         `CHK("timing err", 1'b1, tim_err)
         #1;
         rpos = 5'(pr[r] - 1);
         repeat (3) @(posedge mclk);
         `CHK("timing err", 1'b0, tim_err)
         #1;
      end
      // Divide-by-six is left under reset so that no half-counted gap is judged.
      arst_n = 1'b0;
      dcode  = 5'h00;
      @(posedge mclk);
      #1;
      arst_n = 1'b1;
      `CHK("ctl reset", 8'h00, crd)
      `CHK("addr reset", 16'h0000, ard)
      for (int r = 0; r < 6; r++) begin
         {dcode, hdiv, stretch} = {5'(rc[r]), 4'(rh[r]), 8'(rs[r])};
         repeat (3) @(posedge mclk);
         `CHK("rate err", re[r][0], rate_err)
         #1;
      end
      {three, turbo, prev, dcode, rpos} = {1'b1, 3'h1, 3'h2, 5'h00, 5'h00};
      gap(1'b0, n);
      gap(1'b0, n);
      `CHK("preview pclk", 12, n)
      gap(1'b1, n);
      gap(1'b1, n);
      `CHK("preview reset", 24, n)
      #1;
      {prev, dcode} = {3'h0, 5'h0a};
      for (int f = 0; f < 4; f++) begin
         {t, h, k} = {tt[f], hh[f], (f == 0) ? 24 : 4};
         {turbo, hdiv, three} = {3'(t), 4'(h), f != 2};
         for (int g = 0; g < k; g++) begin
            s = 0;
            for (int j = 0; j < t * h; j++) begin
               px[g*t*h+j] = $random(seed) & 'h3fff;
               cl[g*t*h+j] = ($random(seed) & 'hff) % 3;
               if (j < t) s += px[g*t*h+j];
               if (j == t - 1) c = (f == 2) ? 1 : cl[g*t*h+j];
            end
            of[g] = $random(seed) & 'hfff;
            gn[g] = (f == 1 && g < 2) ? g * 'h4000 : $random(seed) & 'hffff;
            ex[g] = want(s / t, of[g], gn[g], c);
         end
         i_host.put(2'h0, 16'h0000);
         i_host.put(2'h1, 16'h0000);
         for (int g = 0; g < k; g++) i_host.word(16'(of[g] << 2));
         i_host.put(2'h0, 16'h0010);
         i_host.put(2'h1, 16'h0000);
         for (int g = 0; g < k; g++) i_host.word(16'(gn[g]));
         for (int g = 0; g < k; g++) begin
            i_host.put(2'h0, {10'h000, 2'h2, ex[g][23:22], 2'h2});
            i_host.put(2'h1, {4'h0, ex[g][21:10]});
            i_host.put(2'h2, {8'h00, gv(ex[g][21:10], ex[g][23:22])});
            q.push_back(ex[g]);
         end
         if (f == 0) hold = cyc + 120;
         lstart = 1'b1;
         @(posedge mclk);
         #1;
         lstart = 1'b0;
         for (int j = 0; j < k * t * h; j++) send(px[j], cl[j]);
         pvalid = 1'b0;
         for (int i = 0; i < 400 && q.size() != 0; i++) @(posedge mclk);
         #1;
         `CHK("pending", 0, q.size())
         if (f == 0) `CHK("fifo refused", 1'b1, full)
      end
      `CHK("drained", 1'b0, ovalid)
      give_verdict();
   end
endmodule // scn_pix_tb
`default_nettype wire
